// file: design/ext_mem_byte_wait_dma_ctrl.sv
// What this block does
// (R1) Without byte mode each access is one whole word cycle at an even address.
// (R2) Byte select is captured in data setup; outside drives or ties it high.
// (R3) Byte mode splits a word: low byte at A0 low, then high byte A0 high.
// (R4) Second byte cycle uses data 0-7, upper strobe idle, data 8-15 floated.
// (R5) Single byte write in byte mode runs both cycles, lower strobe in matching one.
// (R6) Wait request high stretches data setup by one processor cycle, two halves.
// (R7) Outside wait logic holds wait request stable near the sampling edge.
// (R8) Wait still high in the second wait half adds another wait state.
// (R9) During an external cycle bus request is sampled in first high phase.
// (R10) Between external cycles bus request is sampled in every high phase.
// (R11) Address, data, strobes and chip enable float before and during the grant.
// (R12) Request removal drops the grant; driving resumes in the next low phase.
// (R13) Grant only between cycles; processor external access stalls until grant ends.
// (R14) Outside keeps chip enable and strobes inactive during handover, with pull-ups.
// (R15) Request held through reset gives the grant before boot begins.
// (R16) Grant follows within two cycles plus waits, doubled in byte mode.
// (R17) Each cycle has four half phases; only data setup is stretched.
// (R18) Lower strobe for low byte, upper for high byte, both for word writes.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_byte_wait_dma_ctrl
    import ext_mem_pkg::*;
(
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Processor side access request.
    input  wire logic                          cpu_req,
    input  wire logic                          cpu_write,
    input  wire logic [1:0]                    cpu_byte_en,
    input  wire logic [ext_mem_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic [ext_mem_pkg::DATA_W-1:0] cpu_wdata,
    output logic                               cpu_ack,
    output logic      [ext_mem_pkg::DATA_W-1:0] cpu_rdata,
    // Processor clock output.
    output logic                               proc_clock_out_a,
    // External memory pins.
    output logic      [ext_mem_pkg::ADDR_W-1:0] address_bus_lines,
    output logic                               address_bus_oe,
    input  wire logic [ext_mem_pkg::DATA_W-1:0] data_bus_in,
    output logic      [ext_mem_pkg::DATA_W-1:0] data_bus_lines,
    output logic      [1:0]                    data_bus_oe,
    output logic                               chip_enable_n,
    output logic                               lower_byte_write_strobe_n,
    output logic                               upper_byte_write_strobe_n,
    output logic                               control_oe,
    input  wire logic                          byte_access_select,
    input  wire logic                          wait_request,
    // Bus request and grant.
    input  wire logic                          bus_request,
    output logic                               bus_granted
);

    typedef struct packed {
        logic                 pclk;
        phase_t               phase;
        logic                 byte_mode;
        logic                 second;
        logic                 write;
        logic [1:0]           ben;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
        logic [DATA_W-1:0]    rdata;
        logic                 ack;
        logic                 sampled;
        logic                 granted;
        logic                 floating;
        logic                 bus_oe;
        logic [ADDR_W-1:0]    addr_pin;
        logic [DATA_W-1:0]    data_pin;
        logic [1:0]           data_oe;
        logic                 ce_n;
        logic                 wr0_n;
        logic                 wr1_n;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;
    logic        req_s;
    logic        bacc_s;
    logic        wait_s;
    logic [DATA_W-1:0] din_s;

    // Pin inputs pass two flip-flops before use.
    sync_two_ff #(.WIDTH(3 + DATA_W)) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({bus_request, byte_access_select, wait_request, data_bus_in}),
        .sync_out ({req_s, bacc_s, wait_s, din_s})
    );

    // Phase sequencing, pin levels and request/grant handshake.
    always_comb begin
        logic high_now;
        logic sample_now;
        high_now   = 1'b0;
        sample_now = 1'b0;
        next_state = state;
        next_state.pclk = ~state.pclk;
        next_state.ack  = 1'b0;
        high_now = (state.pclk == PCLK_HIGH);
        // Request is sampled in high phases: every one when idle, else the first after CE falls.
        if (high_now) begin
            if (state.phase == PH_IDLE) begin
                sample_now = 1'b1; // R10
            end else if (!state.sampled && !state.ce_n) begin
                sample_now = 1'b1; // R9
                next_state.sampled = 1'b1;
            end
        end
        if (sample_now && state.phase == PH_IDLE) begin
            // Grant only between cycles; float first, grant one processor cycle later.
            if (req_s && !state.floating) begin
                next_state.floating = 1'b1; // R11 R13
            end else if (req_s && state.floating) begin
                next_state.granted = 1'b1; // R11 R15 R16
            end else if (!req_s && state.granted) begin
                next_state.granted = 1'b0; // R12
            end
        end
        // Resume driving in the low phase after the grant is dropped.
        if (!high_now && !state.granted && state.floating && !req_s) begin
            next_state.floating = 1'b0; // R12
        end
        case (state.phase)
            PH_IDLE: begin
                // Cycles start in a low phase; processor waits while bus is given away.
                if (!high_now && cpu_req && !state.floating && !state.granted && !req_s) begin
                    next_state.phase   = PH_ADDR; // R13 R17
                    next_state.sampled = 1'b0;
                    next_state.second  = 1'b0;
                    next_state.byte_mode = 1'b0; // Latched afresh in data setup.
                    next_state.write   = cpu_write;
                    next_state.ben     = cpu_byte_en;
                    next_state.addr    = {cpu_addr[ADDR_W-1:1], 1'b0}; // R1 R3
                    next_state.wdata   = cpu_wdata;
                end
            end
            PH_ADDR: begin
                next_state.phase = PH_SETUP;
            end
            PH_SETUP: begin
                if (!state.second) begin
                    next_state.byte_mode = bacc_s; // R2
                end
                next_state.phase = wait_s ? PH_WAIT1 : PH_XFER; // R6 R17
            end
            PH_WAIT1: begin
                next_state.phase = PH_WAIT2; // R6
            end
            PH_WAIT2: begin
                next_state.phase = wait_s ? PH_WAIT1 : PH_XFER; // R8
            end
            PH_XFER: begin
                next_state.phase = PH_HOLD;
            end
            PH_HOLD: begin
                // Read data reaches din_s two clocks late, so the value that stood
                // while chip enable was low is taken here.
                if (!state.write) begin
                    if (state.second) begin
                        next_state.rdata[DATA_W-1:BYTE_W] = din_s[BYTE_W-1:0]; // R4
                    end else if (state.byte_mode) begin
                        next_state.rdata[BYTE_W-1:0] = din_s[BYTE_W-1:0];
                    end else begin
                        next_state.rdata = din_s; // R1
                    end
                end
                if (state.byte_mode && !state.second) begin
                    next_state.phase   = PH_ADDR; // R3
                    next_state.second  = 1'b1;
                    next_state.addr    = {state.addr[ADDR_W-1:1], 1'b1}; // R3
                end else begin
                    next_state.phase = PH_IDLE;
                    next_state.ack   = 1'b1;
                end
            end
            default: begin
                next_state.phase = PH_IDLE;
            end
        endcase
        // Pin levels follow the next phase.
        next_state.addr_pin = next_state.addr;
        next_state.ce_n     = !(next_state.phase inside {PH_SETUP, PH_WAIT1, PH_WAIT2,
                                                         PH_XFER});
        next_state.wr0_n    = 1'b1;
        next_state.wr1_n    = 1'b1;
        next_state.data_oe  = 2'h0;
        next_state.data_pin = next_state.wdata;
        if (next_state.phase != PH_IDLE && next_state.write) begin
            if (next_state.second) begin
                next_state.data_pin[BYTE_W-1:0] = next_state.wdata[DATA_W-1:BYTE_W]; // R4
                next_state.wr0_n   = !next_state.ben[1]; // R5
                next_state.data_oe = {1'b0, next_state.phase != PH_ADDR}; // R4
            end else if (next_state.byte_mode) begin
                next_state.wr0_n   = !next_state.ben[0]; // R5
                next_state.data_oe = {1'b0, next_state.phase != PH_ADDR};
            end else begin
                next_state.wr0_n   = !next_state.ben[0]; // R18
                next_state.wr1_n   = !next_state.ben[1]; // R18
                if (next_state.phase != PH_ADDR) begin
                    next_state.data_oe = next_state.ben;
                end
            end
        end
        // A floated bus drives no data lane and no control line.
        next_state.bus_oe = !next_state.floating; // R11
        if (next_state.floating) begin
            next_state.data_oe = 2'h0; // R11
        end
    end

    // One register holds all state; reset clears it, grant and float included, but sets chip enable, strobes and bus_oe high.
    always_ff @(posedge clk) begin
        if (rst) begin
            state          <= '0;
            state.phase    <= PH_IDLE;
            state.addr     <= ADDR_RESET;
            state.addr_pin <= ADDR_RESET;
            state.wdata    <= DATA_RESET;
            state.ce_n     <= 1'b1;
            state.wr0_n    <= 1'b1;
            state.wr1_n    <= 1'b1;
            state.bus_oe   <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Outputs come straight from the state register.
    assign proc_clock_out_a          = state.pclk;
    assign address_bus_lines         = state.addr_pin;
    assign address_bus_oe            = state.bus_oe; // R11
    assign data_bus_lines            = state.data_pin;
    assign data_bus_oe               = state.data_oe;
    assign chip_enable_n             = state.ce_n;
    assign lower_byte_write_strobe_n = state.wr0_n;
    assign upper_byte_write_strobe_n = state.wr1_n;
    assign control_oe                = state.bus_oe; // R11
    assign bus_granted               = state.granted;
    assign cpu_ack                   = state.ack;
    assign cpu_rdata                 = state.rdata;

endmodule : ext_mem_byte_wait_dma_ctrl
`default_nettype wire

// file: design/ext_mem_pkg.sv
package ext_mem_pkg;

    // Bus widths.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // Phase counter of the half-cycle clock output (two system clocks per processor cycle).
    localparam logic [0:0] PCLK_HIGH = 1'h1;

    // Reset values of the pins.
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    // Half-cycle phases of one external cycle; only data setup stretches.
    typedef enum logic [2:0] {
        PH_IDLE  = 3'h0,
        PH_ADDR  = 3'h1,
        PH_SETUP = 3'h2,
        PH_WAIT1 = 3'h3,
        PH_WAIT2 = 3'h4,
        PH_XFER  = 3'h5,
        PH_HOLD  = 3'h6
    } phase_t;

endpackage : ext_mem_pkg

// file: design/sync_two_ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Asynchronous level in, synchronised level out.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // A synchroniser without bits cannot be built.
    if (WIDTH < 1) begin : g_width_check
        $error("sync_two_ff needs WIDTH of at least one.");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // The first stage feeds only the second stage.
    always_comb begin
        next_state        = state;
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    // Both stages clear on reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule : sync_two_ff
`default_nettype wire

// file: tb/ext_mem_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_chk (
    // Clock, reset and processor side.
    input wire logic        clk, rst, cpu_req, cpu_write, cpu_ack, proc_clock_out_a,
    input wire logic [1:0]  cpu_byte_en, data_bus_oe,
    // Memory pins and bus handshake.
    input wire logic [15:0] address_bus_lines,
    input wire logic        address_bus_oe, chip_enable_n, lower_byte_write_strobe_n,
    input wire logic        upper_byte_write_strobe_n, control_oe, byte_access_select,
    input wire logic        wait_request, bus_request, bus_granted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A driven chip enable falling marks the start of data setup.
    sequence cyc_start;
        $fell(chip_enable_n) && control_oe;
    endsequence
    sequence word_start;
        cyc_start ##0 (!byte_access_select && !$past(byte_access_select, 4));
    endsequence
    AST_CLK_TOGGLE: assert property (!$past(rst) |-> proc_clock_out_a != $past(proc_clock_out_a)) else $error("clock output stalled");
    AST_FLOAT: assert property (bus_granted |-> !address_bus_oe && !control_oe && data_bus_oe == 2'h0) else $error("bus driven in grant");
    AST_FLOAT_FIRST: assert property ($rose(bus_granted) |-> $past(address_bus_oe) == 1'b0 && $past(control_oe) == 1'b0) else $error("float late");
    AST_GRANT_BETWEEN: assert property ($rose(bus_granted) |-> $past(chip_enable_n)) else $error("grant in cycle");
    AST_CE_SPAN: assert property (cyc_start |-> !chip_enable_n [*2]) else $error("cycle too short");
    AST_WAIT: assert property (cyc_start ##0 $past(wait_request) |-> !chip_enable_n [*4]) else $error("no wait state");
    AST_EVEN_WORD: assert property (word_start |-> !address_bus_lines[0]) else $error("odd word address");
    AST_SECOND_BYTE: assert property (!chip_enable_n && control_oe && address_bus_lines[0] |-> upper_byte_write_strobe_n && !data_bus_oe[1]) else $error("second byte lanes");
    AST_WORD_WRITE: assert property (word_start ##0 (cpu_write && cpu_byte_en == 2'h3) |-> !lower_byte_write_strobe_n && !upper_byte_write_strobe_n) else $error("word strobes");
    AST_GRANT_BOUND: assert property ($rose(bus_request) && !wait_request |-> ##[1:30] bus_granted) else $error("grant late");
    AST_GRANT_DROP: assert property ($fell(bus_request) |-> ##[1:8] !bus_granted) else $error("grant held");
    AST_STALL: assert property (bus_granted && cpu_req |-> chip_enable_n && !cpu_ack)
        else $error("access in grant");
endmodule : ext_mem_chk
bind ext_mem_byte_wait_dma_ctrl ext_mem_chk chk_u (.clk, .rst, .cpu_req, .cpu_write, .cpu_ack,
    .proc_clock_out_a, .cpu_byte_en, .data_bus_oe, .address_bus_lines, .address_bus_oe,
    .chip_enable_n, .lower_byte_write_strobe_n, .upper_byte_write_strobe_n, .control_oe,
    .byte_access_select, .wait_request, .bus_request, .bus_granted);
`default_nettype wire

// file: tb/ext_mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_partner (
    // Clock and memory pins as seen from the memory.
    input wire logic        clk, addr_oe, ctl_oe, ce_n, wr0_n, wr1_n,
    input wire logic [1:0]  data_oe,
    input wire logic [15:0] addr, wdata,
    output logic     [15:0] rdata
);
    logic [7:0]  mem [0:255];
    logic [15:0] junk = 16'h5A5A;
    logic        ce_q = 1'b1, w0_q = 1'b1, w1_q = 1'b1;
    logic [15:0] a_q, d_q;
    // Pull-ups keep floated control lines inactive.
    wire logic ce = ctl_oe ? ce_n : 1'b1;
    // Both lanes read at once; an odd address returns its byte on lanes 0-7.
    assign rdata = (!ce && addr_oe) ? {mem[addr[7:0] | 8'h01], mem[addr[7:0]]} : junk;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    // Bytes are written as chip enable rises, one per active strobe.
    always @(posedge clk) begin
        if (ce && !ce_q && !w0_q) mem[a_q[7:0]] <= d_q[7:0];
        if (ce && !ce_q && !w1_q) mem[a_q[7:0] | 8'h01] <= d_q[15:8];
        ce_q <= ce;
        w0_q <= ctl_oe ? wr0_n : 1'b1;
        w1_q <= ctl_oe ? wr1_n : 1'b1;
        a_q <= addr;
        // A lane that is not driven reads back as the inverse of its last value.
        d_q <= {data_oe[1] ? wdata[15:8] : ~wdata[15:8], data_oe[0] ? wdata[7:0] : ~wdata[7:0]};
        junk <= ~junk;
    end
endmodule : ext_mem_partner
`default_nettype wire

// file: tb/test_ext_mem_byte_wait_dma_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_ext_mem_byte_wait_dma_ctrl;
    import ext_mem_pkg::*;
    logic clk = 0, rst = 1, cpu_req = 0, cpu_write = 0, byte_access_select = 0, wait_request = 0;
    logic bus_request = 1, cpu_ack, proc_clock_out_a, address_bus_oe, chip_enable_n, control_oe;
    logic lower_byte_write_strobe_n, upper_byte_write_strobe_n, bus_granted;
    logic [1:0] cpu_byte_en = 2'h3, data_bus_oe;
    logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000, cpu_rdata, address_bus_lines;
    logic [15:0] data_bus_lines, data_bus_in, q;
    int errors = 0, check_count = 0, cycles = 0, k, kw;
    ext_mem_byte_wait_dma_ctrl dut_u (.clk, .rst, .cpu_req, .cpu_write, .cpu_byte_en, .cpu_addr,
        .cpu_wdata, .cpu_ack, .cpu_rdata, .proc_clock_out_a, .address_bus_lines, .address_bus_oe,
        .data_bus_in, .data_bus_lines, .data_bus_oe, .chip_enable_n, .lower_byte_write_strobe_n,
        .upper_byte_write_strobe_n, .control_oe, .byte_access_select, .wait_request, .bus_request,
        .bus_granted);
    ext_mem_partner mem_u (.clk, .addr_oe(address_bus_oe), .ctl_oe(control_oe), .ce_n(chip_enable_n),
        .wr0_n(lower_byte_write_strobe_n), .wr1_n(upper_byte_write_strobe_n), .data_oe(data_bus_oe),
        .addr(address_bus_lines), .wdata(data_bus_lines), .rdata(data_bus_in));
    initial forever #50 clk = ~clk;
    // Cut a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // One processor access held until acknowledged; k counts its cycles.
    task automatic access(input logic w, input logic [1:0] be, input logic [15:0] a, d);
        k = 0;
        cpu_req <= 1'b1;
        cpu_write <= w;
        cpu_byte_en <= be;
        cpu_addr <= a;
        cpu_wdata <= d;
        do begin @(posedge clk); k++; end while (cpu_ack !== 1'b1 && k < 300);
        q = cpu_rdata;
        cpu_req <= 1'b0;
        `CHK(k < 300, 1'b1)
        @(posedge clk);
    endtask : access
    task automatic wait_grant(input logic v);
        for (int n = 0; n < 40 && bus_granted !== v; n++) @(posedge clk);
        `CHK(bus_granted, v)
    endtask : wait_grant
    task automatic t_boot;
        wait_grant(1'b1);
        `CHK({address_bus_oe, control_oe, data_bus_oe}, 4'h0)
        cpu_req <= 1'b1;
        for (int n = 0; n < 10; n++) begin @(posedge clk); `CHK(cpu_ack, 1'b0) end
        bus_request <= 1'b0;
        access(1'b0, 2'h3, 16'h0000, 16'h0000);
        `CHK(bus_granted, 1'b0)
        $display("boot grant test done");
    endtask : t_boot
    task automatic t_word;
        access(1'b1, 2'h3, 16'h0010, 16'hA55A);
        `CHK({mem_u.mem[17], mem_u.mem[16]}, 16'hA55A)
        access(1'b1, 2'h1, 16'h0010, 16'h00C3);
        `CHK({mem_u.mem[17], mem_u.mem[16]}, 16'hA5C3)
        access(1'b0, 2'h3, 16'h0010, 16'h0000);
        kw = k;
        `CHK(q, 16'hA5C3)
        $display("word test done");
    endtask : t_word
    task automatic t_byte;
        byte_access_select <= 1'b1;
        repeat (4) @(posedge clk);
        access(1'b1, 2'h3, 16'h0020, 16'h1234);
        `CHK({mem_u.mem[33], mem_u.mem[32]}, 16'h1234)
        access(1'b1, 2'h2, 16'h0020, 16'hAB00);
        `CHK({mem_u.mem[33], mem_u.mem[32]}, 16'hAB34)
        access(1'b0, 2'h3, 16'h0020, 16'h0000);
        `CHK(q, 16'hAB34)
        `CHK(k >= kw + 4, 1'b1)
        byte_access_select <= 1'b0;
        repeat (4) @(posedge clk);
        $display("byte test done");
    endtask : t_byte
    task automatic t_wait;
        wait_request <= 1'b1;
        fork
            access(1'b0, 2'h3, 16'h0010, 16'h0000);
            begin repeat (12) @(posedge clk); wait_request <= 1'b0; end
        join
        `CHK(q, 16'hA5C3)
        `CHK(k >= kw + 6, 1'b1)
        $display("wait test done");
    endtask : t_wait
    task automatic t_dma;
        fork
            access(1'b1, 2'h3, 16'h0030, 16'hBEEF);
            begin repeat (3) @(posedge clk); bus_request <= 1'b1; end
        join
        wait_grant(1'b1);
        `CHK({mem_u.mem[49], mem_u.mem[48]}, 16'hBEEF)
        bus_request <= 1'b0;
        wait_grant(1'b0);
        $display("dma test done");
    endtask : t_dma
    // Reset with the bus requested, then the scenarios in turn.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_word();
        t_byte();
        t_wait();
        t_dma();
        report_and_stop();
    end
endmodule : test_ext_mem_byte_wait_dma_ctrl
`default_nettype wire
